// ==== core/drpsc_pkg.sv ====
// Package: constants and types for the DDR2 refresh and power-state host
// Operation
// RL1: Auto-refresh: CS, RAS, CAS low, WE high.
// RL2: Refresh only after banks idle tRP.
// RL3: Wait tRFC before next refresh or activate.
// RL4: At most eight posted refreshes, gap 9 tREFI.
// RL5: Self-refresh entry: refresh code with CKE low.
// RL6: ODT off tAOFD before entry, until tXSRD.
// RL7: Hold CKE low throughout self-refresh.
// RL8: Clock may stop one clock after entry.
// RL9: Reads wait tXSRD, others wait tXSNR.
// RL10: Keep CKE high, NOP during exit interval.
// RL11: Power-down entry: CKE low with NOP.
// RL12: No CKE drop during register set, burst.
// RL13: Power-down type and exit speed by A12.
// RL14: Device gates buffers and DLL in power-down.
// RL15: Keep CKE low, leave within 9 tREFI.
// RL16: Exit with NOP, wait tXP or tXARD(S).
// RL17: Active power-down waits RL plus BL/2.
// RL18: After writes wait write recovery before entry.
// RL19: Power-down allowed after refresh or tMRD.
// RL20: NOP and deselect leave operations untouched.
// RL21: Frequency change in self-refresh or precharge power-down.
// RL22: After change, DLL reset, ODT off 200 clocks.
// RL23: Every row refreshed within 64 ms.
// RL24: Device sees self-refresh exit asynchronously.
package drpsc_pkg;

  localparam int TCK_PS      = 4000;
  localparam int TRP_PS      = 15000;
  localparam int TRFC_PS     = 127500;
  localparam int TXSNR_PS    = TRFC_PS + 10000;
  localparam int TREFI_PS    = 7800000;
  localparam int TAOFD_PS    = 2500;
  // Least times round up, the refresh interval rounds down
  localparam int TRP_CK      = (TRP_PS + TCK_PS - 1) / TCK_PS;
  localparam int TRFC_CK     = (TRFC_PS + TCK_PS - 1) / TCK_PS;
  localparam int TXSNR_CK    = (TXSNR_PS + TCK_PS - 1) / TCK_PS;
  localparam int TAOFD_CK    = (TAOFD_PS + TCK_PS - 1) / TCK_PS;
  localparam int TREFI_CK    = TREFI_PS / TCK_PS;
  localparam int TXSRD_CK    = 200;
  localparam int TDLL_CK     = 200;
  localparam int TXP_CK      = 2;
  localparam int TXARD_CK    = 2;
  localparam int TXARDS_CK   = 7;
  localparam int TCKE_CK     = 3;
  localparam int TCKSTAB_CK  = 16;
  localparam int FCHG_GAP_CK = 2;
  localparam int PD_HOLD_CK  = (TAOFD_CK + FCHG_GAP_CK > TCKE_CK) ?
                               TAOFD_CK + FCHG_GAP_CK : TCKE_CK;
  localparam int MAX_POSTED  = 8;
  localparam int PD_LIMIT_CK = 9 * TREFI_CK;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_EMRS = 12'h008;
  localparam logic [2:0]  BA_EMR1   = 3'h1;

  typedef logic [15:0] drpsc_cnt_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } drpsc_cmd_t;

  localparam drpsc_cmd_t CMD_NOP = 4'h7;
  localparam drpsc_cmd_t CMD_AR  = 4'h1;
  localparam drpsc_cmd_t CMD_MRS = 4'h0;

  typedef struct packed {
    logic       ck_run;
    logic       cke;
    logic       odt;
    drpsc_cmd_t cmd;
    logic [2:0] ba;
    logic [13:0] addr;
  } drpsc_pins_t;

  // Control word, bit 0 is ref_en
  typedef struct packed {
    logic odt_en;
    logic clk_stop;
    logic rows_open;
    logic freq_chg;
    logic slow_exit;
    logic pd_req;
    logic sr_req;
    logic ref_en;
  } drpsc_ctrl_t;

  localparam drpsc_ctrl_t CTRL_RST = 8'h01;
  localparam logic [13:0] EMRS_RST = 14'h0000;

  typedef struct packed {
    logic       clk_chg_ok;
    logic       cmd_ok;
    logic       rd_ok;
    logic [3:0] owed;
    logic [3:0] state;
  } drpsc_stat_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_REF, ST_ODT_OFF, ST_SR, ST_CLK_UP,
    ST_PD, ST_EXIT, ST_RELOCK
  } drpsc_state_t;

endpackage : drpsc_pkg

// ==== core/drpsc_timer.sv ====
// Down-counting wait timer with a done flag
`timescale 1ns/1ps
`default_nettype none
module drpsc_timer
  import drpsc_pkg::*;
#(
  parameter drpsc_cnt_t RST_VAL = 16'h0000
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire drpsc_cnt_t val,
  output logic            done
);

  drpsc_cnt_t cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= RST_VAL;
    end else if (load) begin
      cnt_q <= val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign done = (cnt_q == '0);

endmodule : drpsc_timer
`default_nettype wire

// ==== core/drpsc_apb.sv ====
// APB slave holding the control, status and mode-value registers
`timescale 1ns/1ps
`default_nettype none
module drpsc_apb
  import drpsc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output drpsc_ctrl_t       ctrl_q,
  output logic [13:0]       emrs_q,
  input  wire drpsc_stat_t  stat
);

  logic        wr_en;
  logic        hit;
  logic        err_q;
  logic [31:0] rdata_d;

  // Zero-wait slave: read data is captured in setup, shown in access
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign pslverr = psel && penable && err_q;

  always_comb begin
    rdata_d = '0;
    hit     = 1'b1;
    case (paddr)
      ADDR_CTRL: rdata_d = 32'(ctrl_q);
      ADDR_STAT: rdata_d = 32'(stat);
      ADDR_EMRS: rdata_d = 32'(emrs_q);
      default:   hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      err_q  <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? '0 : rdata_d;
      err_q  <= !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      emrs_q <= EMRS_RST;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_q <= drpsc_ctrl_t'(pwdata[7:0]);
    end else if (wr_en && paddr == ADDR_EMRS) begin
      emrs_q <= pwdata[13:0];
    end
  end

endmodule : drpsc_apb
`default_nettype wire

// ==== core/drpsc_host.sv ====
// Refresh and power-state host driving the DDR2 control pins
`timescale 1ns/1ps
`default_nettype none
module drpsc_host
  import drpsc_pkg::*;
#(
  parameter int PD_MAX_CK = PD_LIMIT_CK
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output drpsc_pins_t      ddr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  drpsc_state_t st_q, st_d;
  drpsc_ctrl_t  ctrl;
  drpsc_stat_t  stat;
  drpsc_cmd_t   cmd_q, cmd_d;
  drpsc_cnt_t   t_val;
  drpsc_cnt_t   refi_q;
  drpsc_cnt_t   pd_cnt_q;
  drpsc_cnt_t   since_ar_q;
  drpsc_cnt_t   nop_run_q;
  drpsc_cnt_t   odt_low_q;
  logic [13:0]  emrs;
  logic [13:0]  addr_q;
  logic [2:0]   ba_q;
  logic [3:0]   owed_q;
  logic         cke_q, cke_d;
  logic         ck_run_q, ck_d;
  logic         odt_q, odt_d;
  logic         t_ld, t_done, r_ld, r_done;
  logic         ar_go, sr_go, mrs_go;
  logic         in_sr_q, chg_q;
  logic         tick, urgent, pd_over, clk_chg_ok, ar_issue;

  function automatic drpsc_cnt_t exit_lat(input logic open_rows,
                                          input logic slow);
    exit_lat = open_rows ? (slow ? drpsc_cnt_t'(TXARDS_CK)
                                 : drpsc_cnt_t'(TXARD_CK))
                         : drpsc_cnt_t'(TXP_CK);
  endfunction : exit_lat

  function automatic logic is_nop(input drpsc_cmd_t c);
    is_nop = c.cs_n || (c == CMD_NOP);
  endfunction : is_nop

  // ----------------------------------------------------------------
  // Register slave and timers
  // ----------------------------------------------------------------
  drpsc_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl_q  (ctrl),
    .emrs_q  (emrs),
    .stat    (stat)
  );

  // The reset value covers the idle time after any earlier precharge
  drpsc_timer #(.RST_VAL(drpsc_cnt_t'(TRP_CK))) u_wait (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (t_ld),
    .val     (t_val),
    .done    (t_done)
  );

  drpsc_timer #(.RST_VAL(16'h0000)) u_rdgap (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (r_ld),
    .val     (drpsc_cnt_t'(TXSRD_CK)),
    .done    (r_done)
  );

  assign stat = '{clk_chg_ok: clk_chg_ok, cmd_ok: (st_q == ST_IDLE),
                  rd_ok: r_done, owed: owed_q, state: st_q};
  assign ddr  = '{ck_run: ck_run_q, cke: cke_q, odt: odt_q, cmd: cmd_q,
                  ba: ba_q, addr: addr_q};

  assign urgent  = (owed_q >= 4'(MAX_POSTED));
  // Leave room for the clock restart so CKE rises inside the limit
  assign pd_over = (int'(pd_cnt_q) >= PD_MAX_CK - TCKSTAB_CK - 2);
  // RL21 frequency change window
  assign clk_chg_ok = t_done && (st_q == ST_SR ||
                      (st_q == ST_PD && !ctrl.rows_open && !odt_q));
  assign ar_issue = cke_q && (cmd_q == CMD_AR);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cmd_d  = CMD_NOP;
    cke_d  = cke_q;
    ck_d   = ck_run_q;
    t_ld   = 1'b0;
    t_val  = '0;
    r_ld   = 1'b0;
    ar_go  = 1'b0;
    sr_go  = 1'b0;
    mrs_go = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // RL2 refresh only once the idle timer has run out
        if (t_done) begin
          if (ctrl.ref_en && owed_q != 4'h0 && !ctrl.rows_open) begin
            // RL1 refresh encoding
            cmd_d = CMD_AR;
            ar_go = 1'b1;
            t_ld  = 1'b1;
            t_val = drpsc_cnt_t'(TRFC_CK);
            st_d  = ST_REF;
          end else if (ctrl.sr_req && !ctrl.rows_open) begin
            // RL5 RL6 banks idle, ODT drops first
            t_ld  = 1'b1;
            t_val = drpsc_cnt_t'(TAOFD_CK);
            st_d  = ST_ODT_OFF;
          end else if (ctrl.pd_req && !urgent) begin
            // RL11 RL12 RL17 RL18 RL19 NOP entry from idle
            cke_d = 1'b0;
            t_ld  = 1'b1;
            t_val = drpsc_cnt_t'(PD_HOLD_CK);
            st_d  = ST_PD;
          end
        end
      end
      ST_REF: begin
        // RL3 wait refresh cycle time
        if (t_done) begin
          st_d = ST_IDLE;
        end
      end
      ST_ODT_OFF: begin
        if (t_done) begin
          // RL5 refresh encoding with CKE low
          cmd_d = CMD_AR;
          cke_d = 1'b0;
          sr_go = 1'b1;
          t_ld  = 1'b1;
          t_val = 16'h0001;
          st_d  = ST_SR;
        end
      end
      ST_SR: begin
        // RL7 RL8 CKE held low, clock may stop
        if (t_done && ctrl.sr_req) begin
          ck_d = !ctrl.clk_stop;
        end else if (t_done) begin
          ck_d  = 1'b1;
          t_ld  = 1'b1;
          t_val = drpsc_cnt_t'(TCKSTAB_CK);
          st_d  = ST_CLK_UP;
        end
      end
      ST_CLK_UP: begin
        // RL8 RL9 stable clock, then exit timers
        if (t_done) begin
          cke_d = 1'b1;
          t_ld  = 1'b1;
          t_val = in_sr_q ? drpsc_cnt_t'(TXSNR_CK)
                          : exit_lat(ctrl.rows_open, ctrl.slow_exit);
          r_ld  = in_sr_q;
          st_d  = ST_EXIT;
        end
      end
      ST_PD: begin
        // RL15 forced exit on refresh debt or duration
        if (t_done && (!ctrl.pd_req || urgent || pd_over)) begin
          if (!ck_run_q) begin
            ck_d  = 1'b1;
            t_ld  = 1'b1;
            t_val = drpsc_cnt_t'(TCKSTAB_CK);
            st_d  = ST_CLK_UP;
          end else begin
            // RL16 exit latency by power-down type
            cke_d = 1'b1;
            t_ld  = 1'b1;
            t_val = exit_lat(ctrl.rows_open, ctrl.slow_exit);
            st_d  = ST_EXIT;
          end
        end else if (clk_chg_ok) begin
          ck_d = !ctrl.clk_stop;
        end
      end
      ST_EXIT: begin
        // RL10 only NOP until the exit time is met
        if (t_done && chg_q) begin
          // RL22 DLL reset after frequency change
          cmd_d  = CMD_MRS;
          mrs_go = 1'b1;
          t_ld   = 1'b1;
          t_val  = drpsc_cnt_t'(TDLL_CK);
          st_d   = ST_RELOCK;
        end else if (t_done) begin
          st_d = ST_IDLE;
        end
      end
      ST_RELOCK: begin
        if (t_done) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= ST_IDLE;
      cmd_q    <= CMD_NOP;
      cke_q    <= 1'b1;
      ck_run_q <= 1'b1;
    end else begin
      st_q     <= st_d;
      cmd_q    <= cmd_d;
      cke_q    <= cke_d;
      ck_run_q <= ck_d;
    end
  end

  // Address bus only carries the mode value; refresh ignores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ba_q   <= '0;
      addr_q <= '0;
    end else begin
      ba_q   <= mrs_go ? BA_EMR1 : '0;
      addr_q <= mrs_go ? emrs : '0;
    end
  end

  // ----------------------------------------------------------------
  // ODT, self-refresh and frequency-change flags
  // ----------------------------------------------------------------
  // RL6 ODT back only after tXSRD; RL22 off while relocking
  assign odt_d = ctrl.odt_en && (st_d == ST_IDLE) && r_done && !chg_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odt_q <= 1'b0;
    end else begin
      odt_q <= odt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sr_q <= 1'b0;
    end else if (sr_go) begin
      in_sr_q <= 1'b1;
    end else if (st_q == ST_EXIT && t_done) begin
      in_sr_q <= 1'b0;
    end
  end

  // Setting wins over the clear by the reset command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_q <= 1'b0;
    end else if (clk_chg_ok && ctrl.freq_chg) begin
      chg_q <= 1'b1;
    end else if (mrs_go) begin
      chg_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Refresh debt and power-down duration
  // ----------------------------------------------------------------
  // RL23 one refresh owed per interval keeps the rolling window
  assign tick = (refi_q == '0) && !in_sr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refi_q <= drpsc_cnt_t'(TREFI_CK - 1);
    end else if (tick) begin
      refi_q <= drpsc_cnt_t'(TREFI_CK - 1);
    end else if (!in_sr_q) begin
      refi_q <= refi_q - 16'h0001;
    end
  end

  // RL4 posted refreshes capped, self-refresh clears the debt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owed_q <= 4'h0;
    end else if (sr_go) begin
      owed_q <= tick ? 4'h1 : 4'h0;
    end else if (tick && !ar_go && !urgent) begin
      owed_q <= owed_q + 4'h1;
    end else if (ar_go && !tick) begin
      owed_q <= owed_q - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_cnt_q <= '0;
    end else if (!cke_q && !in_sr_q) begin
      pd_cnt_q <= pd_cnt_q + 16'h0001;
    end else begin
      pd_cnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Check helpers and assertions
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_ar_q <= '1;
      nop_run_q  <= '0;
      odt_low_q  <= '0;
    end else begin
      since_ar_q <= ar_issue ? 16'h0001 :
                    (since_ar_q == '1 ? since_ar_q : since_ar_q + 16'h0001);
      nop_run_q  <= !is_nop(cmd_q) ? '0 :
                    (nop_run_q == '1 ? nop_run_q : nop_run_q + 16'h0001);
      odt_low_q  <= odt_q ? '0 :
                    (odt_low_q == '1 ? odt_low_q : odt_low_q + 16'h0001);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sr_entry;
    $fell(cke_q) && cmd_q == CMD_AR;
  endsequence

  sequence s_sr_exit;
    $rose(cke_q) && in_sr_q;
  endsequence

  chk_ar_spacing: assert property (ar_issue |-> // RL3
    since_ar_q >= 16'(TRFC_CK)) else $error("refresh spacing under tRFC");
  chk_ar_idle: assert property (ar_issue |-> // RL2
    nop_run_q >= 16'(TRP_CK)) else $error("refresh before tRP idle");
  chk_sr_odt_off: assert property (s_sr_entry |-> // RL6
    odt_low_q >= 16'(TAOFD_CK)) else $error("ODT not off before entry");
  chk_sr_cke_low: assert property ((st_q == ST_SR) |-> // RL7
    !cke_q) else $error("CKE high in self-refresh");
  chk_clk_stop_cke: assert property (!ck_run_q |-> // RL8
    !cke_q && $past(!cke_q)) else $error("clock stopped with CKE high");
  chk_exit_nop: assert property (s_sr_exit |-> // RL10
    (cke_q && is_nop(cmd_q))[*8]) else $error("command during exit");
  chk_exit_read_gap: assert property (s_sr_exit |-> // RL9
    (!r_done)[*8]) else $error("read allowed too early after exit");
  chk_cke_fall_cmd: assert property ($fell(cke_q) |-> // RL11
    is_nop(cmd_q) || cmd_q == CMD_AR) else $error("bad command at entry");
  chk_cke_rise_nop: assert property ($rose(cke_q) |-> // RL16
    is_nop(cmd_q) ##1 is_nop(cmd_q)) else $error("command at exit");
  chk_pd_limit: assert property (!cke_q |-> // RL15
    int'(pd_cnt_q) < PD_MAX_CK) else $error("power-down too long");
  chk_owed_cap: assert property (owed_q <= 4'(MAX_POSTED) // RL4
    ) else $error("refresh debt above limit");
  chk_relock_odt: assert property ((st_q == ST_RELOCK) |-> // RL22
    !odt_q && $past(cmd_q) != CMD_AR) else $error("ODT on during relock");

endmodule : drpsc_host
`default_nettype wire

// ==== verif/drpsc_ddr_model.sv ====
// Behavioural DDR2 device model with checks on the host's pin timing
`timescale 1ns/1ps
`default_nettype none
module drpsc_ddr_model
  import drpsc_pkg::*;
#(
  parameter int PD_MAX_CK = PD_LIMIT_CK
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire drpsc_pins_t ddr,
  output logic             in_sr,
  output logic             in_pd,
  output int               n_ref,
  output int               n_pd,
  output int               n_mrs,
  output logic [2:0]       mrs_ba,
  output logic [13:0]      mrs_addr,
  output int               viol
);
  logic cke_q, odt_q, sr_d, nop, bad;
  int   gap, xcnt, pdcnt, run_n, lock;

  // Deselect acts exactly like a no-operation
  assign nop = ddr.cmd.cs_n || (ddr.cmd == CMD_NOP);

  // Left on CKE alone: the clock may still be stopped
  always @(posedge pclk or posedge ddr.cke or negedge presetn) begin
    if (!presetn) begin
      in_sr <= 1'b0;
    end else if (ddr.cke) begin
      in_sr <= 1'b0;
    end else if (cke_q && ddr.cmd == CMD_AR && !in_pd) begin
      in_sr <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Pin checks, only on edges the device really receives
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cke_q, odt_q, sr_d, in_pd} <= 4'h8;
      gap <= TRFC_CK;
      {xcnt, pdcnt, run_n, lock, n_ref, n_pd, n_mrs, viol} <= '0;
      {mrs_ba, mrs_addr} <= '0;
    end else begin
      bad = 1'b0;
      run_n <= ddr.ck_run ? run_n + 1 : 0;
      if (ddr.ck_run) begin
        cke_q <= ddr.cke;
        odt_q <= ddr.odt;
        sr_d <= in_sr;
        gap <= gap + 1;
        // Refresh decoded from pins, spaced by the cycle time
        if (!in_sr && !in_pd && cke_q && ddr.cmd == CMD_AR) begin
          bad = bad | (gap < TRFC_CK);
          gap <= 0;
          n_ref <= n_ref + (ddr.cke ? 1 : 0);
        end
        // Termination already off when self-refresh starts
        if (in_sr && !sr_d) bad = bad | ddr.odt | odt_q;
        // Clock stable before exit, then no-ops with CKE high
        if (sr_d && !in_sr) begin
          bad = bad | (run_n < 2);
          xcnt <= TXSNR_CK - 2;
        end else if (xcnt > 0) begin
          bad = bad | !ddr.cke | !nop;
          xcnt <= xcnt - 1;
        end
        // Power-down entry, with banks precharged or open
        if (!in_sr && !in_pd && cke_q && !ddr.cke && nop) begin
          in_pd <= 1'b1;
          pdcnt <= 0;
          n_pd <= n_pd + 1;
        end
        // Inputs ignored, stay bounded, exit by no-op
        if (in_pd) begin
          pdcnt <= pdcnt + 1;
          bad = bad | (pdcnt > PD_MAX_CK);
          if (ddr.cke) begin
            in_pd <= 1'b0;
            bad = bad | !nop;
            xcnt <= TXP_CK - 1;
          end
        end
        // Termination held off through the DLL relock
        if (cke_q && ddr.cke && ddr.cmd == CMD_MRS) begin
          n_mrs <= n_mrs + 1;
          mrs_ba <= ddr.ba;
          mrs_addr <= ddr.addr;
          lock <= TDLL_CK;
        end else if (lock > 0) begin
          bad = bad | ddr.odt;
          lock <= lock - 1;
        end
      end
      if (bad) viol <= viol + 1;
    end
  end
endmodule : drpsc_ddr_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the DDR2 refresh and power-state host
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import drpsc_pkg::*;
;
  // Short power-down limit keeps the run brief
  localparam int PDMAX = 400;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        err, in_sr, in_pd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  mrs_ba;
  logic [13:0] mrs_addr;
  drpsc_pins_t ddr;
  int          n_ref, n_pd, n_mrs, viol, n_errors, cmp_count;

  drpsc_host #(.PD_MAX_CK(PDMAX)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ddr(ddr));
  drpsc_ddr_model #(.PD_MAX_CK(PDMAX)) dev (
    .pclk(pclk), .presetn(presetn), .ddr(ddr), .in_sr(in_sr),
    .in_pd(in_pd), .n_ref(n_ref), .n_pd(n_pd), .n_mrs(n_mrs),
    .mrs_ba(mrs_ba), .mrs_addr(mrs_addr), .viol(viol));

  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns in the same step
    @(posedge pclk);
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_st(input logic [3:0] s);
    int k;
    k = 0;
    apb(1'b0, ADDR_STAT, 32'h0);
    while (rd[3:0] !== s && k < 4000) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      k++;
    end
    chk("state", {28'h0, s}, {28'h0, rd[3:0]});
  endtask : wait_st

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RST}, rd);
    apb(1'b0, ADDR_EMRS, 32'h0);
    chk("emrs reset", {18'h0, EMRS_RST}, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, ADDR_STAT, 32'hffff_ffff);
    chk("stat write err", 32'h0, {31'h0, err});
    wait_st(ST_IDLE);
    repeat (TREFI_CK + 150) @(posedge pclk);
    chk("first refresh", 32'h1, n_ref);
    // Refresh held off until eight are owed; power-down then refused
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (8 * TREFI_CK + 200) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("owed", 32'h8, {28'h0, rd[7:4]});
    apb(1'b1, ADDR_CTRL, 32'h04);
    repeat (40) @(posedge pclk);
    chk("pd refused", 32'h0, n_pd);
    apb(1'b1, ADDR_CTRL, 32'h01);
    repeat (8 * 40 + 100) @(posedge pclk);
    chk("drained", 32'h9, n_ref);
    apb(1'b1, ADDR_CTRL, 32'h2d);
    wait_st(ST_PD);
    chk("pd cke", 32'h0, {31'h0, ddr.cke});
    repeat (PDMAX + 50) @(posedge pclk);
    chk("pd limit", 32'h1, {31'h0, (n_pd > 1) || !in_pd});
    apb(1'b1, ADDR_CTRL, 32'h01);
    wait_st(ST_IDLE);
    chk("pd left", 32'h0, {31'h0, in_pd});
    // Self-refresh with a stopped clock and a frequency change
    apb(1'b1, ADDR_CTRL, 32'h81);
    apb(1'b1, ADDR_EMRS, 32'h0100);
    chk("odt on", 32'h1, {31'h0, ddr.odt});
    apb(1'b1, ADDR_CTRL, 32'hc3);
    wait_st(ST_SR);
    repeat (10) @(posedge pclk);
    chk("sr entered", 32'h1, {31'h0, in_sr});
    chk("sr odt", 32'h0, {31'h0, ddr.odt});
    chk("clock stopped", 32'h0, {31'h0, ddr.ck_run});
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("clk change ok", 32'h1, {31'h0, rd[10]});
    apb(1'b1, ADDR_CTRL, 32'hd3);
    apb(1'b1, ADDR_CTRL, 32'h91);
    wait_st(ST_IDLE);
    chk("sr left", 32'h0, {31'h0, in_sr});
    chk("dll reset", 32'h1, n_mrs);
    chk("mrs bank", {29'h0, BA_EMR1}, {29'h0, mrs_ba});
    chk("mrs value", 32'h0100, {18'h0, mrs_addr});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl kept", 32'h91, rd);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("read ok", 32'h1, {31'h0, rd[8]});
    chk("cmd ok", 32'h1, {31'h0, rd[9]});
    chk("odt back", 32'h1, {31'h0, ddr.odt});
    chk("device checks", 32'h0, viol);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
